//--- hdl/cce_pkg.sv
// Package for the configuration chain enable cascade block.
package cce_pkg;

  // ----------------------------------------------------------------
  // Configuration schemes.
  // ----------------------------------------------------------------
  // Scheme that the device is strapped for.
  typedef enum logic [1:0] {
    CCE_FAST_PARALLEL_SCHEME,
    CCE_ACTIVE_SERIAL_SCHEME,
    CCE_PASSIVE_SERIAL_SCHEME,
    CCE_BOUNDARY_SCAN_SCHEME
  } cce_scheme_t;

  // ----------------------------------------------------------------
  // Widths and constants.
  // ----------------------------------------------------------------
  // Width of the fast parallel data bus.
  localparam int CCE_DATA_W = 8;
  // Open-drain enable value while the pin is pulled low.
  localparam logic CCE_OE_DRIVE = 1'b0;
  // Open-drain enable value while the pin is released.
  localparam logic CCE_OE_RELEASE = 1'b1;

  // ----------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------
  // Open-drain pin seen from the design: output, enable (low drives).
  typedef struct packed {
    logic out_lvl;
    logic oe_n;
  } cce_od_pin_t;

  // Requests from the device's configuration engine.
  typedef struct packed {
    logic load_done;
    logic load_error;
  } cce_engine_t;

endpackage : cce_pkg

//--- hdl/cce_cascade.sv
// Chip-enable cascade, shared complete/status lines and data lane gating.
//
// Behaviour
// [RL1] Boundary-scan load needs chip enable held low.
// [RL2] Chain enables daisy-chain; first grounded, last open.
// [RL3] Drive chain enable low once loading finishes.
// [RL4] Shared complete/status lines release user mode together.
// [RL5] Shared lines demand loading every chain device.
// [RL6] Scan order matches chain, or enables grounded.
// [RL7] After scan load succeeds, drive chain enable low.
// [RL8] Bit zero all but scan; upper bits parallel.
// [RL9] High complete line after scan means success.
// [RL10] Shared lines are driven only open-drain.
module cce_cascade (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire cce_pkg::cce_scheme_t scheme_in,
  input wire logic chip_enable_n_in,
  input wire logic [cce_pkg::CCE_DATA_W-1:0] config_data_in,
  input wire cce_pkg::cce_engine_t engine_in,
  input wire logic config_complete_line_in,
  input wire logic status_line_in,
  output cce_pkg::cce_od_pin_t config_complete_line_out,
  output cce_pkg::cce_od_pin_t status_line_out,
  output logic chain_enable_n_out,
  output logic load_active_out,
  output logic user_mode_out,
  output logic [cce_pkg::CCE_DATA_W-1:0] load_data_out,
  output logic load_data_valid_out
);
  import cce_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  // Two-stage synchronisers; stage one is read only by stage two.
  logic ce_s1_q, ce_s2_q;
  logic done_s1_q, done_s2_q;
  logic stat_s1_q, stat_s2_q;
  logic [CCE_DATA_W-1:0] dat_s1_q, dat_s2_q;

  // Captures the asynchronous pins.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ce_s1_q <= 1'b1;
      ce_s2_q <= 1'b1;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      stat_s1_q <= 1'b0;
      stat_s2_q <= 1'b0;
      dat_s1_q <= '0;
      dat_s2_q <= '0;
    end else begin
      ce_s1_q <= chip_enable_n_in;
      ce_s2_q <= ce_s1_q;
      done_s1_q <= config_complete_line_in;
      done_s2_q <= done_s1_q;
      stat_s1_q <= status_line_in;
      stat_s2_q <= stat_s1_q;
      dat_s1_q <= config_data_in;
      dat_s2_q <= dat_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing.
  // ----------------------------------------------------------------
  // Loader phases.
  typedef enum logic [1:0] {WAIT_ENABLE, LOADING, LOADED, USER} cce_state_t;
  cce_state_t state_q;
  // Set once the local load completed; held until reset.
  logic own_done_q;
  logic chain_en_n_q; // Registered chain enable, active low.
  logic user_q; // Registered user-mode flag.
  logic err_q; // Load error seen; pulls the status line low.

  // Chip enable low starts the load; in scan mode the holder keeps it low.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= WAIT_ENABLE;
    end else begin
      case (state_q)
        // Idle until the previous device pulls our chip enable low.
        WAIT_ENABLE: begin
          if (!ce_s2_q) begin
            state_q <= LOADING; // RL1 RL2
          end
        end
        // Loading; an error returns us to waiting.
        LOADING: begin
          if (engine_in.load_error) begin
            state_q <= WAIT_ENABLE;
          end else if (engine_in.load_done) begin
            state_q <= LOADED;
          end
        end
        // Wait for every device to release the shared lines.
        LOADED: begin
          if (done_s2_q && stat_s2_q) begin
            state_q <= USER; // RL4 RL5 RL9
          end
        end
        // Remain in user mode until reset.
        USER: begin
          state_q <= USER;
        end
        default: begin
          state_q <= WAIT_ENABLE;
        end
      endcase
    end
  end

  // Records successful completion of this device's own load.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      own_done_q <= 1'b0;
    end else if (state_q == LOADING && engine_in.load_done && !engine_in.load_error) begin
      own_done_q <= 1'b1;
    end
  end

  // Chain enable goes low after own load, also in scan order mode.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chain_en_n_q <= 1'b1;
    end else begin
      chain_en_n_q <= !own_done_q; // RL3 RL6 RL7
    end
  end

  // Error flag pulls the shared status line low while set.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_q <= 1'b0;
    end else if (state_q == LOADING && engine_in.load_error) begin
      err_q <= 1'b1;
    end else if (!ce_s2_q && state_q == WAIT_ENABLE && err_q) begin
      err_q <= 1'b0;
    end
  end

  // User mode follows the USER state one cycle later and stays set until reset.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_q <= 1'b0;
    end else begin
      user_q <= (state_q == USER);
    end
  end

  // ----------------------------------------------------------------
  // Data lane gating.
  // ----------------------------------------------------------------
  // Which data lanes the current scheme uses.
  function automatic logic [CCE_DATA_W-1:0] lane_mask(input cce_scheme_t s);
    case (s)
      CCE_FAST_PARALLEL_SCHEME: lane_mask = '1;
      CCE_BOUNDARY_SCAN_SCHEME: lane_mask = '0;
      default: lane_mask = {{(CCE_DATA_W-1){1'b0}}, 1'b1};
    endcase
  endfunction : lane_mask

  logic [CCE_DATA_W-1:0] data_q;
  logic valid_q;

  // Registers the lanes in use; unused lanes read zero.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_q <= '0;
      valid_q <= 1'b0;
    end else begin
      data_q <= dat_s2_q & lane_mask(scheme_in); // RL8
      valid_q <= (state_q == LOADING) && (scheme_in != CCE_BOUNDARY_SCAN_SCHEME); // RL8
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  // Open-drain: only ever low or released.
  assign config_complete_line_out.out_lvl = 1'b0; // RL10
  assign config_complete_line_out.oe_n = own_done_q ? CCE_OE_RELEASE : CCE_OE_DRIVE; // RL10
  assign status_line_out.out_lvl = 1'b0; // RL10
  assign status_line_out.oe_n = err_q ? CCE_OE_DRIVE : CCE_OE_RELEASE; // RL10
  assign chain_enable_n_out = chain_en_n_q;
  assign load_active_out = (state_q == LOADING);
  assign user_mode_out = user_q;
  assign load_data_out = data_q;
  assign load_data_valid_out = valid_q;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  chain_after_done_a: assert property ($rose(own_done_q) |=> $fell(chain_enable_n_out)) // RL3
    else $error("chain enable not low after load done");
  chain_hold_a: assert property (!own_done_q |=> chain_enable_n_out) // RL7
    else $error("chain enable low before own load done");
  user_needs_lines_a: assert property ($rose(user_mode_out) |-> $past(done_s2_q, 2)) // RL4
    else $error("user mode without shared complete high");
  success_high_a: assert property (state_q == LOADED && done_s2_q && stat_s2_q // RL9
    |=> state_q == USER)
    else $error("complete high did not mark success");
  od_low_only_a: assert property (!config_complete_line_out.out_lvl // RL10
    && !status_line_out.out_lvl)
    else $error("shared line driven high");
  done_release_a: assert property (state_q == LOADED |-> config_complete_line_out.oe_n) // RL10
    else $error("complete line held after load");
  scan_no_data_a: assert property (scheme_in == CCE_BOUNDARY_SCAN_SCHEME // RL8
    |=> !load_data_valid_out && load_data_out == '0)
    else $error("data lanes used in scan scheme");
  start_on_enable_a: assert property (state_q == WAIT_ENABLE && !ce_s2_q // RL1
    |=> load_active_out)
    else $error("load did not start on chip enable");
  err_pull_a: assert property (state_q == LOADING && engine_in.load_error // RL4
    |=> status_line_out.oe_n == CCE_OE_DRIVE)
    else $error("status line not pulled on load error");

  cov_load_c: cover property (load_active_out ##[1:50] $fell(chain_enable_n_out));
  cov_user_c: cover property ($rose(user_mode_out));
  cov_err_c: cover property (load_active_out && engine_in.load_error);
  cov_status_c: cover property ($fell(status_line_out.oe_n));
endmodule : cce_cascade

//--- verification/cce_prev_dev.sv
// Model of the preceding chain device and the rest of the shared line.
module cce_prev_dev (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire logic hold_in,
  output logic chain_enable_n_out,
  output logic complete_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic done_q; // Own load finished.
  // Once its load is over it enables the next device and releases its line.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_q <= 1'b0;
    end else if (go_in) begin
      done_q <= 1'b1;
    end
  end
  assign chain_enable_n_out = !done_q;
  // A later device still loading keeps the shared line low.
  assign complete_oe_n_out = done_q && !hold_in;
endmodule : cce_prev_dev

//--- verification/config_chain_enable_cascade_tb_top.sv
// Self-checking bench for the chip-enable cascade block.
module config_chain_enable_cascade_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cce_pkg::*;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
  logic clk = 1'b0, rstn = 1'b0, go = 1'b0, hold = 1'b0, stat_hold = 1'b0, ce_n, peer_oe_n;
  cce_scheme_t scheme = CCE_FAST_PARALLEL_SCHEME;
  logic [CCE_DATA_W-1:0] data = 8'ha5, dout;
  cce_engine_t eng = '0;
  cce_od_pin_t cl_o, st_o;
  logic chen_n, act, user, dval, seen;
  int failures = 0, total_checks = 0, cycles = 0, k;
  // Shared lines carry pull-ups; any enabled driver pulls them low.
  wire complete_line = cl_o.oe_n & peer_oe_n;
  wire status_line = st_o.oe_n & !stat_hold;
  cce_prev_dev peer (.core_clk_in(clk), .rstn_in(rstn), .go_in(go), .hold_in(hold),
    .chain_enable_n_out(ce_n), .complete_oe_n_out(peer_oe_n));
  cce_cascade dut (.core_clk_in(clk), .rstn_in(rstn), .scheme_in(scheme),
    .chip_enable_n_in(ce_n), .config_data_in(data), .engine_in(eng),
    .config_complete_line_in(complete_line), .status_line_in(status_line),
    .config_complete_line_out(cl_o), .status_line_out(st_o), .chain_enable_n_out(chen_n),
    .load_active_out(act), .user_mode_out(user), .load_data_out(dout),
    .load_data_valid_out(dval));
  initial begin
    forever #2 clk = ~clk;
  end
  // A hang is cut short after a fixed number of cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end
  task give_verdict();
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task do_reset(input cce_scheme_t s);
    @(posedge clk);
    rstn <= 1'b0;
    go <= 1'b0;
    hold <= 1'b0;
    stat_hold <= 1'b0;
    scheme <= s;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
  endtask : do_reset
  task pulse(input logic d, input logic e);
    @(posedge clk);
    eng <= '{load_done: d, load_error: e};
    @(posedge clk);
    eng <= '0;
  endtask : pulse
  // Enable the block and wait for it to start loading.
  task start();
    @(posedge clk);
    go <= 1'b1;
    for (k = 0; k < 8 && act !== 1'b1; k++) @(negedge clk);
    `CHK("load_active", 1'b1, act)
  endtask : start
  task finish_load();
    pulse(1'b1, 1'b0);
    for (k = 0; k < 6 && chen_n !== 1'b0; k++) @(negedge clk);
  endtask : finish_load
  // Reset levels, early done ignored, full-width data, shared release.
  task t_parallel();
    do_reset(CCE_FAST_PARALLEL_SCHEME);
    `CHK("chain_en_rst", 1'b1, chen_n)
    `CHK("complete_oe_rst", CCE_OE_DRIVE, cl_o.oe_n)
    `CHK("status_oe_rst", CCE_OE_RELEASE, st_o.oe_n)
    pulse(1'b1, 1'b0);
    repeat (4) @(negedge clk);
    `CHK("chain_en_early", 1'b1, chen_n)
    start();
    repeat (4) @(negedge clk);
    `CHK("data_par", 8'ha5, dout)
    `CHK("valid_par", 1'b1, dval)
    `CHK("user_busy", 1'b0, user)
    @(posedge clk);
    hold <= 1'b1;
    stat_hold <= 1'b1;
    finish_load();
    `CHK("chain_en_done", 1'b0, chen_n)
    `CHK("complete_oe", CCE_OE_RELEASE, cl_o.oe_n)
    `CHK("complete_lvl", 1'b0, cl_o.out_lvl)
    repeat (8) @(negedge clk);
    `CHK("user_held", 1'b0, user)
    @(posedge clk);
    hold <= 1'b0;
    repeat (8) @(negedge clk);
    `CHK("user_status_low", 1'b0, user)
    @(posedge clk);
    stat_hold <= 1'b0;
    for (k = 0; k < 8 && user !== 1'b1; k++) @(negedge clk);
    `CHK("user_joint", 1'b1, user)
  endtask : t_parallel
  // Serial schemes pass only the lowest data bit.
  task t_serial(input cce_scheme_t s);
    do_reset(s);
    start();
    repeat (4) @(negedge clk);
    `CHK("data_ser", 8'h01, dout)
    `CHK("valid_ser", 1'b1, dval)
  endtask : t_serial
  // Scan load uses no data pins and hands on after success.
  task t_scan();
    do_reset(CCE_BOUNDARY_SCAN_SCHEME);
    start();
    repeat (4) @(negedge clk);
    `CHK("valid_scan", 1'b0, dval)
    `CHK("data_scan", 8'h00, dout)
    finish_load();
    `CHK("chain_en_scan", 1'b0, chen_n)
    for (k = 0; k < 8 && user !== 1'b1; k++) @(negedge clk);
    `CHK("user_scan", 1'b1, user)
  endtask : t_scan
  // A load error pulls status low and never hands on.
  task t_error();
    do_reset(CCE_PASSIVE_SERIAL_SCHEME);
    start();
    pulse(1'b0, 1'b1);
    seen = 1'b0;
    for (k = 0; k < 6; k++) begin
      @(negedge clk);
      if (st_o.oe_n === CCE_OE_DRIVE) seen = 1'b1;
    end
    `CHK("status_err", 1'b1, seen)
    `CHK("status_lvl", 1'b0, st_o.out_lvl)
    `CHK("chain_en_err", 1'b1, chen_n)
    `CHK("user_err", 1'b0, user)
  endtask : t_error
  initial begin
    t_parallel();
    t_serial(CCE_ACTIVE_SERIAL_SCHEME);
    t_serial(CCE_PASSIVE_SERIAL_SCHEME);
    t_scan();
    t_error();
    give_verdict();
  end
endmodule : config_chain_enable_cascade_tb_top
